/* File: pkg/psb_defines.svh */
// Constants for the peripheral slot bridge: window, slot decode, timing.
// Assumes a 32-bit byte address from the crossbar and a 50 MHz system bus clock.
// Contract
// - One bridge decodes a 1024 KB window starting at the peripheral base.
// - All window traffic enters through one crossbar slave port.
// - First 128 KB: 32 slots of 4 KB, each with its own enable.
// - Next 384 KB: 96 slots of 4 KB, each with its own enable.
// - Slot 255 at 0x400F_F000 aliases the I/O module of slot 15.
// - Alias accesses take a direct path without bridge wait states.
// - A cleared clock gate bit disables that module's slot.
// - Access to an unimplemented or disabled slot ends in transfer error.
// - Unimplemented offset inside an enabled slot also ends in transfer error.
// - Slot 0 at 0x4000_0000, spacing 0x1000; slot 15 is the I/O controller.
`ifndef PSB_DEFINES_SVH
`define PSB_DEFINES_SVH

`define PSB_ADDR_W        32
`define PSB_DATA_W        32
`define PSB_WIN_TAG       12'h400
`define PSB_WIN_TAG_LSB   20
`define PSB_WIN_KB        1024
`define PSB_SLOT_LSB      12
`define PSB_SLOT_MSB      19
`define PSB_SLOT_BYTES    32'h0000_1000
`define PSB_ON_SLOTS      32
`define PSB_OFF_SLOTS     96
`define PSB_NUM_SLOTS     128
`define PSB_ALIAS_CODE    8'hFF
`define PSB_ALIAS_TARGET  7'h0F
`define PSB_SLOT_MAP      128'h0000_0000_0000_0000_0B00_0001_0000_8000
`define PSB_WAIT_STATES   8'h01
`define PSB_TIMEOUT       8'hFF
`define PSB_CNT_RST       8'h00
`define PSB_SLOT_RST      7'h00
`define PSB_OFS_RST       12'h000
`define PSB_DATA_RST      32'h0000_0000

`endif

/* File: pkg/psb_pkg.sv */
// Types shared by the peripheral slot bridge and its surroundings.
// Assumes psb_defines.svh is on the include path.
`include "psb_defines.svh"

package psb_pkg;

    typedef logic [`PSB_ADDR_W-1:0] psb_addr_t;
    typedef logic [`PSB_DATA_W-1:0] psb_data_t;
    typedef logic [6:0]             psb_slot_t;

    // Crossbar side request and answer
    typedef struct packed {
        logic      valid;
        logic      write;
        psb_addr_t addr;
        psb_data_t wdata;
    } psb_bus_req_s;

    typedef struct packed {
        logic      valid;
        logic      err;
        psb_data_t rdata;
    } psb_bus_rsp_s;

    // Peripheral side request and answer, shared by all slots
    typedef struct packed {
        logic       write;
        logic [11:0] offset;
        psb_data_t  wdata;
    } psb_per_req_s;

    typedef struct packed {
        logic      ready;
        logic      err;
        psb_data_t rdata;
    } psb_per_rsp_s;

    typedef enum logic [3:0] {
        PSB_IDLE   = 4'h1,
        PSB_SETUP  = 4'h2,
        PSB_ACCESS = 4'h4,
        PSB_DONE   = 4'h8
    } psb_state_e;

endpackage

/* File: logic/psb_bridge.sv */
// Peripheral slot bridge: decodes the crossbar slave port into 4 KB slot enables.
// Assumes one request at a time from the crossbar, peripherals on the same clock,
// and clock gate levels from the system_integration_unit on the same clock.
`timescale 1ns/1ns
`include "psb_defines.svh"

module psb_bridge #(
    parameter logic [`PSB_NUM_SLOTS-1:0] SLOT_MAP    = `PSB_SLOT_MAP,
    parameter logic [7:0]                WAIT_STATES = `PSB_WAIT_STATES,
    parameter logic [7:0]                TIMEOUT     = `PSB_TIMEOUT
) (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    // Crossbar slave port
    input  wire psb_pkg::psb_bus_req_s        bus_req_i,
    output logic                              bus_ready_o,
    output psb_pkg::psb_bus_rsp_s             bus_rsp_o,
    // Clock gate levels, one per slot
    input  wire logic [`PSB_NUM_SLOTS-1:0]    clk_gate_i,
    // Peripheral side
    output logic [`PSB_NUM_SLOTS-1:0]         slot_en_o,
    output logic                              alias_en_o,
    output psb_pkg::psb_per_req_s             per_req_o,
    input  wire psb_pkg::psb_per_rsp_s        per_rsp_i
);

    // Slot index of an address; the alias folds onto its target slot
    function automatic psb_pkg::psb_slot_t slot_of(input psb_pkg::psb_addr_t a);
        logic [7:0] code;
        code = a[`PSB_SLOT_MSB:`PSB_SLOT_LSB];
        if (code == `PSB_ALIAS_CODE)
        begin
            slot_of = `PSB_ALIAS_TARGET;
        end
        else
        begin
            slot_of = code[6:0];
        end
    endfunction

    // True when the address falls on the alias slot at the top of the window
    function automatic logic is_alias(input psb_pkg::psb_addr_t a);
        is_alias = (a[`PSB_SLOT_MSB:`PSB_SLOT_LSB] == `PSB_ALIAS_CODE);
    endfunction

    // True when the address lies in the window and in a decoded region
    function automatic logic in_region(input psb_pkg::psb_addr_t a);
        logic win;
        win = (a[`PSB_ADDR_W-1:`PSB_WIN_TAG_LSB] == `PSB_WIN_TAG);
        // Codes 0x80..0xFE are the reserved hole between slot 127 and the alias
        in_region = win && (!a[`PSB_SLOT_MSB] || is_alias(a));
    endfunction

    // Slot has a module and its clock is running
    function automatic logic slot_live(input psb_pkg::psb_slot_t s,
                                       input logic [`PSB_NUM_SLOTS-1:0] gate);
        slot_live = SLOT_MAP[s] && gate[s];
    endfunction

    // State
    psb_pkg::psb_state_e          state_r;
    psb_pkg::psb_state_e          state_nxt;
    psb_pkg::psb_slot_t           slot_r;
    psb_pkg::psb_slot_t           slot_nxt;
    logic                         alias_r;
    logic                         alias_nxt;
    logic [7:0]                   cnt_r;
    logic [7:0]                   cnt_nxt;
    logic                         write_r;
    logic                         write_nxt;
    logic [11:0]                  ofs_r;
    logic [11:0]                  ofs_nxt;
    psb_pkg::psb_data_t           wdata_r;
    psb_pkg::psb_data_t           wdata_nxt;
    psb_pkg::psb_data_t           rdata_r;
    psb_pkg::psb_data_t           rdata_nxt;
    logic                         err_r;
    logic                         err_nxt;
    logic [`PSB_NUM_SLOTS-1:0]    en_r;
    logic [`PSB_NUM_SLOTS-1:0]    en_nxt;
    logic                         alias_en_r;
    logic                         alias_en_nxt;
    logic [`PSB_NUM_SLOTS-1:0]    onehot;

    // Request decode, valid only while idle
    psb_pkg::psb_slot_t           req_slot;
    logic                         req_alias;
    logic                         req_ok;

    assign req_slot  = slot_of(bus_req_i.addr);
    assign req_alias = is_alias(bus_req_i.addr);
    assign req_ok    = in_region(bus_req_i.addr) && slot_live(req_slot, clk_gate_i);

    // Single slave port: one request in flight, taken only while idle
    assign bus_ready_o = (state_r == psb_pkg::PSB_IDLE);

    // One-hot decode of the next slot number
    genvar g;
    generate
        for (g = 0; g < `PSB_NUM_SLOTS; g++)
        begin : g_slot
            assign onehot[g] = (slot_nxt == 7'(g));
        end
    endgenerate

    always_comb
    begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        rdata_nxt    = rdata_r;
        err_nxt      = err_r;
        unique case (state_r)
            psb_pkg::PSB_IDLE:
            begin
                if (bus_req_i.valid)
                begin
                    rdata_nxt = `PSB_DATA_RST;
                    cnt_nxt   = `PSB_CNT_RST;
                    if (!req_ok)
                    begin
                        // No enable is raised; the master sees the error next cycle
                        err_nxt   = 1'b1;
                        state_nxt = psb_pkg::PSB_DONE;
                    end
                    else if (req_alias || (WAIT_STATES == `PSB_CNT_RST))
                    begin
                        err_nxt   = 1'b0;
                        state_nxt = psb_pkg::PSB_ACCESS;
                    end
                    else
                    begin
                        err_nxt   = 1'b0;
                        state_nxt = psb_pkg::PSB_SETUP;
                    end
                end
            end
            psb_pkg::PSB_SETUP:
            begin
                // Bridge wait states before the slot enable rises
                if (!clk_gate_i[slot_r])
                begin
                    err_nxt   = 1'b1;
                    state_nxt = psb_pkg::PSB_DONE;
                end
                else if (cnt_r + 8'h01 >= WAIT_STATES)
                begin
                    cnt_nxt   = `PSB_CNT_RST;
                    state_nxt = psb_pkg::PSB_ACCESS;
                end
                else
                begin
                    cnt_nxt = cnt_r + 8'h01;
                end
            end
            psb_pkg::PSB_ACCESS:
            begin
                if (per_rsp_i.ready)
                begin
                    rdata_nxt = write_r ? `PSB_DATA_RST : per_rsp_i.rdata;
                    err_nxt   = per_rsp_i.err;
                    state_nxt = psb_pkg::PSB_DONE;
                end
                else if (!clk_gate_i[slot_r])
                begin
                    // Gate pulled mid-access: the module can no longer answer
                    err_nxt   = 1'b1;
                    state_nxt = psb_pkg::PSB_DONE;
                end
                else if (cnt_r >= TIMEOUT)
                begin
                    // A silent peripheral must not hang the crossbar port
                    err_nxt   = 1'b1;
                    state_nxt = psb_pkg::PSB_DONE;
                end
                else
                begin
                    cnt_nxt = cnt_r + 8'h01;
                end
            end
            psb_pkg::PSB_DONE:
            begin
                state_nxt = psb_pkg::PSB_IDLE;
            end
            default:
            begin
                state_nxt = psb_pkg::PSB_IDLE;
                err_nxt   = 1'b0;
            end
        endcase
    end

    // Target slot latched on acceptance; it steers the enables for the whole access
    always_comb
    begin
        slot_nxt  = slot_r;
        alias_nxt = alias_r;
        if ((state_r == psb_pkg::PSB_IDLE) && bus_req_i.valid)
        begin
            slot_nxt  = req_slot;
            alias_nxt = req_alias;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            slot_r  <= `PSB_SLOT_RST;
            alias_r <= 1'b0;
        end
        else
        begin
            slot_r  <= slot_nxt;
            alias_r <= alias_nxt;
        end
    end

    // Captured request, held until the next request is taken so the
    // peripheral sees a steady offset and data through the whole access
    always_comb
    begin
        write_nxt = write_r;
        ofs_nxt   = ofs_r;
        wdata_nxt = wdata_r;
        if ((state_r == psb_pkg::PSB_IDLE) && bus_req_i.valid)
        begin
            write_nxt = bus_req_i.write;
            ofs_nxt   = bus_req_i.addr[`PSB_SLOT_LSB-1:0];
            wdata_nxt = bus_req_i.wdata;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            write_r <= 1'b0;
            ofs_r   <= `PSB_OFS_RST;
            wdata_r <= `PSB_DATA_RST;
        end
        else
        begin
            write_r <= write_nxt;
            ofs_r   <= ofs_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    // Enables follow the access state so only the addressed slot is ever selected
    always_comb
    begin
        if (state_nxt == psb_pkg::PSB_ACCESS)
        begin
            en_nxt       = onehot;
            alias_en_nxt = alias_nxt;
        end
        else
        begin
            en_nxt       = '0;
            alias_en_nxt = 1'b0;
        end
    end

    // Slot enables registered on their own so they never glitch toward the peripherals
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            en_r       <= '0;
            alias_en_r <= 1'b0;
        end
        else
        begin
            en_r       <= en_nxt;
            alias_en_r <= alias_en_nxt;
        end
    end

    // Transfer control and response registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= psb_pkg::PSB_IDLE;
            cnt_r   <= `PSB_CNT_RST;
            rdata_r <= `PSB_DATA_RST;
            err_r   <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            rdata_r <= rdata_nxt;
            err_r   <= err_nxt;
        end
    end

    // Outputs, all from flip-flops except the ready and response valid state decodes
    assign slot_en_o        = en_r;
    assign alias_en_o       = alias_en_r;
    assign per_req_o.write  = write_r;
    assign per_req_o.offset = ofs_r;
    assign per_req_o.wdata  = wdata_r;
    assign bus_rsp_o.valid  = (state_r == psb_pkg::PSB_DONE);
    assign bus_rsp_o.err    = err_r;
    assign bus_rsp_o.rdata  = rdata_r;

endmodule // psb_bridge

/* File: verif/psb_periph_model.sv */
// Peripheral set model behind the slot enables.
// Assumes the bridge clock; wait_i sets the answer delay.
`timescale 1ns/1ns
module psb_periph_model (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // From the bridge
    input  wire logic [127:0]          slot_en_i,
    input  wire psb_pkg::psb_per_req_s per_req_i,
    input  wire logic [3:0]            wait_i,
    // To the bridge
    output psb_pkg::psb_per_rsp_s      per_rsp_o
);
    logic [3:0]         cnt_r;
    psb_pkg::psb_data_t last_r;
    psb_pkg::psb_data_t junk_r;
    logic               sel;
    assign sel = |slot_en_i;
    always_ff @(posedge clk_i)
    begin
        junk_r <= rst_i ? 32'h0000_0000 : junk_r + 32'h9E37_79B9;
        cnt_r <= (rst_i || !sel) ? 4'h0 : cnt_r + {3'h0, cnt_r != 4'hF};
        if (rst_i)
            last_r <= 32'h0000_0000;
        else if (sel && per_rsp_o.ready && per_req_i.write)
            last_r <= per_req_i.wdata;
    end
    // Only the first 16 bytes answer; unselected data churns
    always_comb
    begin
        per_rsp_o.ready = sel && (cnt_r >= wait_i);
        per_rsp_o.err   = sel && (per_req_i.offset >= 12'h010);
        per_rsp_o.rdata = sel ? (last_r ^ {20'h00000, per_req_i.offset}) : junk_r;
    end
endmodule // psb_periph_model

/* File: verif/psb_bridge_props.sv */
// Checker of the bridge ports.
// Assumes WAIT_STATES of 1 for the setup timing.
`timescale 1ns/1ns
module psb_bridge_props #(
    parameter logic [127:0] SLOT_MAP    = 128'h0,
    parameter logic [7:0]   WAIT_STATES = 8'h01,
    parameter logic [7:0]   TIMEOUT     = 8'hFF
) (
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    input wire psb_pkg::psb_bus_req_s bus_req_i,
    input wire logic                  bus_ready_o,
    input wire psb_pkg::psb_bus_rsp_s bus_rsp_o,
    input wire logic [127:0]          clk_gate_i,
    input wire logic [127:0]          slot_en_o,
    input wire logic                  alias_en_o,
    input wire psb_pkg::psb_per_req_s per_req_o,
    input wire psb_pkg::psb_per_rsp_s per_rsp_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       take;
    logic       win;
    logic       ali;
    logic       good;
    logic [6:0] slot;
    logic [6:0] slot_r;
    assign take = bus_req_i.valid && bus_ready_o;
    assign win  = bus_req_i.addr[31:20] == 12'h400;
    assign ali  = bus_req_i.addr[31:12] == 20'h400FF;
    assign slot = bus_req_i.addr[18:12];
    assign good = win && !bus_req_i.addr[19] && SLOT_MAP[slot] && clk_gate_i[slot];
    always_ff @(posedge clk_i)
        slot_r <= take ? slot : slot_r;
    property p_onehot; slot_en_o != 128'h0 |-> $onehot(slot_en_o); endproperty
    property p_pair; alias_en_o |-> slot_en_o[15]; endproperty
    property p_alias;
        take && ali && clk_gate_i[15] && SLOT_MAP[15] |=> alias_en_o && slot_en_o == 128'h8000;
    endproperty
    property p_out; take && !win |=> bus_rsp_o.valid && bus_rsp_o.err; endproperty
    property p_bad;
        take && win && !ali && !good |=> bus_rsp_o.valid && bus_rsp_o.err && slot_en_o == 128'h0;
    endproperty
    property p_pulse; bus_rsp_o.valid |=> !bus_rsp_o.valid && bus_ready_o; endproperty
    property p_perr;
        slot_en_o != 128'h0 && per_rsp_i.ready && per_rsp_i.err |=> bus_rsp_o.valid && bus_rsp_o.err;
    endproperty
    property p_normal;
        take && good |=> slot_en_o == 128'h0 ##1 slot_en_o == (128'h1 << slot_r);
    endproperty
    a_onehot: assert property (p_onehot) else $error("slot enable not one-hot");
    a_pair: assert property (p_pair) else $error("alias enable without slot 15");
    a_alias: assert property (p_alias) else $error("alias path not direct");
    a_out: assert property (p_out) else $error("outside window not refused");
    a_bad: assert property (p_bad) else $error("bad slot not refused");
    a_pulse: assert property (p_pulse) else $error("response not single");
    a_perr: assert property (p_perr) else $error("hole error lost");
    a_normal: assert property (p_normal) else $error("wrong slot enable");
    c_alias: cover property (take && ali);
    c_bad: cover property (take && !good);
    c_perr: cover property (per_rsp_i.ready && per_rsp_i.err);
endmodule // psb_bridge_props
bind psb_bridge psb_bridge_props #(.SLOT_MAP(SLOT_MAP), .WAIT_STATES(WAIT_STATES),
    .TIMEOUT(TIMEOUT)) psb_bridge_props_i (.clk_i(clk_i), .rst_i(rst_i),
    .bus_req_i(bus_req_i), .bus_ready_o(bus_ready_o), .bus_rsp_o(bus_rsp_o),
    .clk_gate_i(clk_gate_i), .slot_en_o(slot_en_o), .alias_en_o(alias_en_o),
    .per_req_o(per_req_o), .per_rsp_i(per_rsp_i));

/* File: verif/tb.sv */
// Testbench of the bridge with a peripheral model.
// Assumes default slot map and wait states, short timeout.
`timescale 1ns/1ns
module tb;
    logic                  clk_i = 1'b0;
    logic                  rst_i = 1'b1;
    psb_pkg::psb_bus_req_s req = '0;
    psb_pkg::psb_bus_rsp_s rsp;
    psb_pkg::psb_per_req_s preq;
    psb_pkg::psb_per_rsp_s prsp;
    logic                  rdy;
    logic                  alias_en;
    logic [127:0]          gate = {128{1'b1}};
    logic [127:0]          slot_en;
    logic [3:0]            wait_c = 4'h0;
    logic                  err;
    psb_pkg::psb_data_t    rdata;
    int                    lat;
    int                    bad_count = 0;
    int                    checked = 0;
    int                    cyc = 0;
    always #10 clk_i = ~clk_i;
    psb_bridge #(.TIMEOUT(8'h08)) psb_bridge_i (.clk_i(clk_i), .rst_i(rst_i),
        .bus_req_i(req), .bus_ready_o(rdy), .bus_rsp_o(rsp), .clk_gate_i(gate),
        .slot_en_o(slot_en), .alias_en_o(alias_en), .per_req_o(preq), .per_rsp_i(prsp));
    psb_periph_model psb_periph_model_i (.clk_i(clk_i), .rst_i(rst_i), .slot_en_i(slot_en),
        .per_req_i(preq), .wait_i(wait_c), .per_rsp_o(prsp));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Request held until the taken edge, then latency counted in edges
    task automatic access(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(negedge clk_i);
        req = '{1'b1, w, a, d};
        while (rdy !== 1'b1)
            @(negedge clk_i);
        @(negedge clk_i);
        req.valid = 1'b0;
        lat = 1;
        while (rsp.valid !== 1'b1 && lat < 40)
        begin
            @(negedge clk_i);
            lat++;
        end
        err = rsp.err;
        rdata = rsp.rdata;
    endtask
    task automatic t_slots();
        logic [31:0] a [5] = '{32'h4000_F004, 32'h4002_0004, 32'h4003_8004,
                               32'h4003_9004, 32'h4003_B004};
        foreach (a[i])
        begin
            access(a[i], 1'b0, 32'h0);
            check(err, 1'b0);
            check(rdata, 32'h0000_0004);
            check(lat, 3);
        end
        $display("slots done");
    endtask
    task automatic t_alias();
        access(32'h400F_F004, 1'b0, 32'h0);
        check(err, 1'b0);
        check(rdata, 32'h0000_0004);
        check(lat, 2);
        wait_c = 4'h3;
        access(32'h400F_F008, 1'b0, 32'h0);
        check(lat, 5);
        wait_c = 4'h0;
        $display("alias done");
    endtask
    task automatic t_errs();
        logic [31:0] a [8] = '{32'h4000_0000, 32'h4003_A000, 32'h4003_C000, 32'h4007_F000,
                               32'h4008_0000, 32'h400F_E000, 32'h4010_0000, 32'h3FFF_F000};
        foreach (a[i])
        begin
            access(a[i], 1'b0, 32'h0);
            check(err, 1'b1);
            check(lat, 1);
        end
        gate[15] = 1'b0;
        gate[32] = 1'b0;
        access(32'h400F_F000, 1'b0, 32'h0);
        check(err, 1'b1);
        access(32'h4002_0000, 1'b1, 32'h0);
        check({err, 6'(lat)}, 7'h41);
        gate = {128{1'b1}};
        $display("errors done");
    endtask
    task automatic t_misc();
        access(32'h4000_F800, 1'b0, 32'h0);
        check({err, 6'(lat)}, 7'h43);
        access(32'h4003_B008, 1'b1, 32'h1234_5678);
        check(err, 1'b0);
        check(rdata, 32'h0000_0000);
        access(32'h4003_B008, 1'b0, 32'h0);
        check(rdata, 32'h1234_5670);
        wait_c = 4'hF;
        access(32'h4002_0000, 1'b0, 32'h0);
        check(err, 1'b1);
        check(lat, 11);
        // Gate pulled in the first access cycle while the peripheral stays silent
        fork
            access(32'h4002_0000, 1'b0, 32'h0);
            begin
                repeat (3) @(negedge clk_i);
                gate[32] = 1'b0;
            end
        join
        check(err, 1'b1);
        check(lat, 3);
        gate = {128{1'b1}};
        wait_c = 4'h0;
        $display("misc done");
    endtask
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Whole run needs under a hundred cycles
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad_count++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        t_slots();
        t_alias();
        t_errs();
        t_misc();
        end_of_test();
    end
endmodule // tb
